// ### otm_pkg.sv
// Shared constants and types of the output timer mode control block
`default_nettype none
package otm_pkg;
    // Register indices; byte address is four times the index
    localparam logic [31:0] IDX_GROUP_A_CONTROL_0 = 32'h0080029A;
    localparam logic [31:0] IDX_GROUP_A_CONTROL_1 = 32'h0080029D;
    localparam logic [31:0] IDX_GROUP_B_CONTROL = 32'h008002AA;
    localparam logic [31:0] IDX_GROUP_C_CONTROL = 32'h008002EA;
    localparam logic [31:0] ADDR_GROUP_A_CONTROL_0 = {IDX_GROUP_A_CONTROL_0[29:0], 2'h0};
    localparam logic [31:0] ADDR_GROUP_A_CONTROL_1 = {IDX_GROUP_A_CONTROL_1[29:0], 2'h0};
    localparam logic [31:0] ADDR_GROUP_B_CONTROL = {IDX_GROUP_B_CONTROL[29:0], 2'h0};
    localparam logic [31:0] ADDR_GROUP_C_CONTROL = {IDX_GROUP_C_CONTROL[29:0], 2'h0};
    // Field positions
    localparam int POS_CHAN3_MODE = 0;
    localparam int POS_CHAN2_MODE = 2;
    localparam int POS_CHAN1_MODE = 4;
    localparam int POS_CHAN0_MODE = 6;
    localparam int POS_GROUP_A_ENABLE_SOURCE = 9;
    localparam int POS_GROUP_A_CLOCK_SOURCE = 14;
    localparam int POS_CHAN5_MODE = 12;
    localparam int POS_CHAN4_MODE = 14;
    localparam int POS_CHAN7_CHAIN_SELECT = 1;
    localparam int POS_CHAN7_MODE = 2;
    localparam int POS_CHAN6_MODE = 6;
    localparam int POS_GROUP_B_ENABLE_SOURCE = 9;
    localparam int POS_GROUP_B_CLOCK_SOURCE = 14;
    localparam int POS_CHAN10_MODE = 2;
    localparam int POS_CHAN9_MODE = 4;
    localparam int POS_CHAN8_MODE = 6;
    localparam int POS_GROUP_C_ENABLE_SOURCE = 11;
    localparam int POS_GROUP_C_CLOCK_SOURCE = 14;
    // Writable bits of each register; all others read zero
    localparam logic [15:0] MASK_GROUP_A_CONTROL_0 = 16'hCEFF;
    localparam logic [15:0] MASK_GROUP_A_CONTROL_1 = 16'hF000;
    localparam logic [15:0] MASK_GROUP_B_CONTROL = 16'hCECE;
    localparam logic [15:0] MASK_GROUP_C_CONTROL = 16'hC8FC;
    localparam logic [15:0] RST_CONTROL = 16'h0000;
    // Operation mode codes; upper bit set means continuous
    localparam logic [1:0] MODE_SINGLE = 2'h0;
    localparam logic [1:0] MODE_DELAYED = 2'h1;
    localparam int NUM_CHAN = 11;

    typedef enum logic [1:0] {PH_IDLE, PH_LOAD, PH_FIRST, PH_SECOND} otm_phase_t;

    typedef struct packed {
        logic [15:0] a0;
        logic [15:0] a1;
        logic [15:0] b;
        logic [15:0] c;
    } otm_regs_t;

    typedef struct packed {
        otm_phase_t phase;
        logic [15:0] cnt;
        logic out;
        logic underflow;
        logic running;
    } otm_chan_t;

    typedef struct packed {
        otm_regs_t regs;
        logic [2:0] sync1;
        logic [2:0] sync2;
        logic [2:0] sync3;
        logic [2:0] trig;
        logic [3:0] src_prev;
        logic [10:0] en_prev;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } otm_top_t;
endpackage
`default_nettype wire

// ### otm_channel.sv
// One down-counting output timer channel with three operation modes
`default_nettype none
module otm_channel (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Control
    input wire logic [1:0] mode_i,
    input wire logic tick_i,
    input wire logic start_i,
    input wire logic stop_i,
    input wire logic [15:0] reload_i,
    input wire logic [15:0] preset_i,
    // Status
    output logic out_o,
    output logic underflow_o,
    output logic running_o
);
    otm_pkg::otm_chan_t s_ff;
    otm_pkg::otm_chan_t nxt_s;

    always_comb begin
        nxt_s = s_ff;
        nxt_s.underflow = 1'b0;
        if (stop_i) begin
            nxt_s.phase = otm_pkg::PH_IDLE; // RULE_18
        end else begin
            case (s_ff.phase)
                otm_pkg::PH_IDLE: begin
                    if (start_i) begin
                        nxt_s.phase = otm_pkg::PH_LOAD;
                        // Delayed mode only flips on underflows
                        if (mode_i != otm_pkg::MODE_DELAYED) begin
                            nxt_s.out = ~s_ff.out; // RULE_16
                        end
                    end
                end
                otm_pkg::PH_LOAD: begin
                    if (tick_i) begin
                        nxt_s.phase = otm_pkg::PH_FIRST;
                        nxt_s.cnt = (mode_i == otm_pkg::MODE_SINGLE) ? reload_i : preset_i; // RULE_16 RULE_17
                    end
                end
                default: begin
                    if (tick_i) begin
                        if (s_ff.cnt == 16'h0000) begin
                            nxt_s.underflow = 1'b1;
                            nxt_s.out = ~s_ff.out;
                            if (mode_i[1]) begin
                                nxt_s.cnt = reload_i; // RULE_18
                            end else if (mode_i == otm_pkg::MODE_DELAYED && s_ff.phase == otm_pkg::PH_FIRST) begin
                                nxt_s.cnt = reload_i; // RULE_17
                                nxt_s.phase = otm_pkg::PH_SECOND;
                            end else begin
                                nxt_s.phase = otm_pkg::PH_IDLE; // RULE_16 RULE_17
                            end
                        end else begin
                            nxt_s.cnt = s_ff.cnt - 16'h0001;
                        end
                    end
                end
            endcase
        end
        // Registered so that the running flag leaves a flip-flop directly
        nxt_s.running = (nxt_s.phase != otm_pkg::PH_IDLE);
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign out_o = s_ff.out;
    assign underflow_o = s_ff.underflow;
    assign running_o = s_ff.running;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_single_stops: assert property (underflow_o && mode_i == otm_pkg::MODE_SINGLE && !start_i |-> !running_o) // RULE_16
        else $error("single-shot channel kept running after underflow");
    a_start_toggle: assert property (!running_o && start_i && !stop_i && !mode_i[1] && mode_i[0] == 1'b0
        |=> out_o != $past(out_o)) // RULE_16
        else $error("single-shot output did not flip at start");
    a_delay_first: assert property (!running_o && start_i && !stop_i && mode_i == otm_pkg::MODE_DELAYED
        |=> out_o == $past(out_o)) // RULE_17
        else $error("delayed output flipped at start");
    a_delay_second: assert property (s_ff.phase == otm_pkg::PH_FIRST && tick_i && s_ff.cnt == 16'h0000 && !stop_i
        && mode_i == otm_pkg::MODE_DELAYED |=> s_ff.phase == otm_pkg::PH_SECOND && s_ff.cnt == $past(reload_i)) // RULE_17
        else $error("delayed first underflow did not reload");
    a_cont_reload: assert property (running_o && s_ff.phase != otm_pkg::PH_LOAD && tick_i && s_ff.cnt == 16'h0000
        && !stop_i && mode_i[1] |=> underflow_o && running_o && out_o != $past(out_o)) // RULE_18
        else $error("continuous underflow did not reload and flip");
    c_cont_run: cover property (mode_i[1] && underflow_o ##1 !underflow_o [*2] ##1 underflow_o);
    c_delay_done: cover property (s_ff.phase == otm_pkg::PH_SECOND && underflow_o);
endmodule
`default_nettype wire

// ### otm_control.sv
// Output timer mode control registers, APB slave and eleven timer channels
// Function
// RULE_01 - Mode field: 00 single-shot, 01 delayed single-shot, 1x continuous.
// RULE_02 - Group A register 0: ch3 bits 0-1, ch2 2-3, ch1 4-5, ch0 6-7.
// RULE_03 - Group A enable source bits 9-11: top bit 0 pin A, else event bus 0-3.
// RULE_04 - Group A clock source bits 14-15 picks clock bus 0 to 3.
// RULE_05 - Group A register 1: ch5 bits 12-13, ch4 bits 14-15, bits 8-11 empty.
// RULE_06 - Channel 7 chain bit 1: 0 group B source, 1 channel 6 output.
// RULE_07 - Group B register: ch7 mode bits 2-3, ch6 mode bits 6-7.
// RULE_08 - Group B enable source bits 9-11: top bit 0 pin B, else event bus 0-3.
// RULE_09 - Group B clock source bits 14-15 picks clock bus by value.
// RULE_10 - Group C register: ch10 bits 2-3, ch9 4-5, ch8 6-7.
// RULE_11 - Group C enable source bit 11: 0 pin C, 1 event bus 3.
// RULE_12 - Group C clock source bits 14-15: 00, 01, 10 pick bus 0, 1, 2.
// RULE_13 - Four control registers, each group sharing enable and clock source.
// RULE_14 - Software uses halfword transfers only on these registers.
// RULE_15 - Software stops a counter before changing its mode.
// RULE_16 - Single-shot: load reload on count clock, flip at start and underflow, stop.
// RULE_17 - Delayed: count preset, first underflow reloads and flips, second flips and stops.
// RULE_18 - Continuous: every underflow reloads and flips until enable is cleared.
// RULE_19 - Unassigned bits read zero and ignore writes.
// RULE_20 - Group C clock code 11 selects clock bus 3.
//
// Local design decision: register access over APB.
`default_nettype none
module otm_control (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Timer sources
    input wire logic [10:0] chan_enable_i,
    input wire logic [10:0][15:0] reload_i,
    input wire logic [10:0][15:0] preset_i,
    input wire logic [3:0] clk_bus_i,
    input wire logic [3:0] event_bus_i,
    input wire logic ext_trigger_a_i,
    input wire logic ext_trigger_b_i,
    input wire logic ext_trigger_c_i,
    // Timer outputs
    output logic [10:0] chan_out_o,
    output logic [10:0] chan_underflow_o,
    output logic [10:0] chan_running_o
);
    otm_pkg::otm_top_t s_ff;
    otm_pkg::otm_top_t nxt_s;
    logic [10:0][1:0] chan_mode;
    logic [10:0] chan_tick;
    logic [10:0] chan_start;
    logic [10:0] chan_stop;
    logic [3:0] src_lvl;
    logic [3:0] src_rise;
    logic [2:0] ens_a;
    logic [2:0] ens_b;
    logic [1:0] cks_a;
    logic [1:0] cks_b;
    logic [1:0] cks_c;
    logic tick_a;
    logic tick_b;
    logic tick_c;
    logic setup;
    logic access_wr;
    logic hit_a0;
    logic hit_a1;
    logic hit_b;
    logic hit_c;

    // Field extraction
    always_comb begin
        chan_mode[0] = s_ff.regs.a0[otm_pkg::POS_CHAN0_MODE +: 2]; // RULE_02
        chan_mode[1] = s_ff.regs.a0[otm_pkg::POS_CHAN1_MODE +: 2]; // RULE_02
        chan_mode[2] = s_ff.regs.a0[otm_pkg::POS_CHAN2_MODE +: 2]; // RULE_02
        chan_mode[3] = s_ff.regs.a0[otm_pkg::POS_CHAN3_MODE +: 2]; // RULE_02
        chan_mode[4] = s_ff.regs.a1[otm_pkg::POS_CHAN4_MODE +: 2]; // RULE_05
        chan_mode[5] = s_ff.regs.a1[otm_pkg::POS_CHAN5_MODE +: 2]; // RULE_05
        chan_mode[6] = s_ff.regs.b[otm_pkg::POS_CHAN6_MODE +: 2]; // RULE_07
        chan_mode[7] = s_ff.regs.b[otm_pkg::POS_CHAN7_MODE +: 2]; // RULE_07
        chan_mode[8] = s_ff.regs.c[otm_pkg::POS_CHAN8_MODE +: 2]; // RULE_10
        chan_mode[9] = s_ff.regs.c[otm_pkg::POS_CHAN9_MODE +: 2]; // RULE_10
        chan_mode[10] = s_ff.regs.c[otm_pkg::POS_CHAN10_MODE +: 2]; // RULE_10
        ens_a = s_ff.regs.a0[otm_pkg::POS_GROUP_A_ENABLE_SOURCE +: 3];
        ens_b = s_ff.regs.b[otm_pkg::POS_GROUP_B_ENABLE_SOURCE +: 3];
        cks_a = s_ff.regs.a0[otm_pkg::POS_GROUP_A_CLOCK_SOURCE +: 2];
        cks_b = s_ff.regs.b[otm_pkg::POS_GROUP_B_CLOCK_SOURCE +: 2];
        cks_c = s_ff.regs.c[otm_pkg::POS_GROUP_C_CLOCK_SOURCE +: 2];
    end

    // Count clock and enable source selection, shared per group
    always_comb begin
        tick_a = clk_bus_i[cks_a]; // RULE_04
        tick_b = clk_bus_i[cks_b]; // RULE_09
        tick_c = clk_bus_i[cks_c]; // RULE_12 RULE_20
        src_lvl[0] = ens_a[2] ? event_bus_i[ens_a[1:0]] : s_ff.trig[0]; // RULE_03
        src_lvl[1] = ens_b[2] ? event_bus_i[ens_b[1:0]] : s_ff.trig[1]; // RULE_08
        src_lvl[2] = s_ff.regs.c[otm_pkg::POS_GROUP_C_ENABLE_SOURCE] ? event_bus_i[3] : s_ff.trig[2]; // RULE_11
        src_lvl[3] = s_ff.regs.b[otm_pkg::POS_CHAN7_CHAIN_SELECT] ? chan_out_o[6] : src_lvl[1]; // RULE_06
        src_rise = src_lvl & ~s_ff.src_prev;
        for (int i = 0; i < otm_pkg::NUM_CHAN; i++) begin
            chan_stop[i] = s_ff.en_prev[i] & ~chan_enable_i[i]; // RULE_18
            chan_start[i] = chan_enable_i[i] & ~s_ff.en_prev[i];
            if (i <= 5) begin
                chan_tick[i] = tick_a;
                chan_start[i] = chan_start[i] | src_rise[0]; // RULE_13
            end else if (i == 6) begin
                chan_tick[i] = tick_b;
                chan_start[i] = chan_start[i] | src_rise[1];
            end else if (i == 7) begin
                chan_tick[i] = tick_b;
                chan_start[i] = chan_start[i] | src_rise[3]; // RULE_06
            end else begin
                chan_tick[i] = tick_c;
                chan_start[i] = chan_start[i] | src_rise[2];
            end
        end
    end

    // Address decode
    always_comb begin
        hit_a0 = 1'b0;
        hit_a1 = 1'b0;
        hit_b = 1'b0;
        hit_c = 1'b0;
        if (paddr_i == otm_pkg::ADDR_GROUP_A_CONTROL_0) begin
            hit_a0 = 1'b1;
        end else if (paddr_i == otm_pkg::ADDR_GROUP_A_CONTROL_1) begin
            hit_a1 = 1'b1;
        end else if (paddr_i == otm_pkg::ADDR_GROUP_B_CONTROL) begin
            hit_b = 1'b1;
        end else if (paddr_i == otm_pkg::ADDR_GROUP_C_CONTROL) begin
            hit_c = 1'b1;
        end
        setup = psel_i & ~penable_i;
        access_wr = psel_i & penable_i & s_ff.pready & pwrite_i & ~s_ff.pslverr;
    end

    // Next state
    always_comb begin
        nxt_s = s_ff;
        // Pin synchronisers; level taken once stages two and three agree
        nxt_s.sync1 = {ext_trigger_c_i, ext_trigger_b_i, ext_trigger_a_i};
        nxt_s.sync2 = s_ff.sync1;
        nxt_s.sync3 = s_ff.sync2;
        for (int k = 0; k < 3; k++) begin
            if (s_ff.sync2[k] == s_ff.sync3[k]) begin
                nxt_s.trig[k] = s_ff.sync3[k];
            end
        end
        nxt_s.src_prev = src_lvl;
        nxt_s.en_prev = chan_enable_i;
        // Answer in the first access cycle
        nxt_s.pready = setup;
        if (setup) begin
            nxt_s.pslverr = ~(hit_a0 | hit_a1 | hit_b | hit_c);
            nxt_s.prdata = 32'h00000000;
            if (hit_a0) begin
                nxt_s.prdata[15:0] = s_ff.regs.a0;
            end else if (hit_a1) begin
                nxt_s.prdata[15:0] = s_ff.regs.a1;
            end else if (hit_b) begin
                nxt_s.prdata[15:0] = s_ff.regs.b;
            end else if (hit_c) begin
                nxt_s.prdata[15:0] = s_ff.regs.c;
            end
        end else begin
            nxt_s.pslverr = 1'b0;
        end
        if (access_wr) begin
            if (hit_a0) begin
                nxt_s.regs.a0 = pwdata_i[15:0] & otm_pkg::MASK_GROUP_A_CONTROL_0; // RULE_19
            end else if (hit_a1) begin
                nxt_s.regs.a1 = pwdata_i[15:0] & otm_pkg::MASK_GROUP_A_CONTROL_1; // RULE_19
            end else if (hit_b) begin
                nxt_s.regs.b = pwdata_i[15:0] & otm_pkg::MASK_GROUP_B_CONTROL; // RULE_19
            end else if (hit_c) begin
                nxt_s.regs.c = pwdata_i[15:0] & otm_pkg::MASK_GROUP_C_CONTROL; // RULE_19
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            s_ff <= '0;
            s_ff.regs.a0 <= otm_pkg::RST_CONTROL;
            s_ff.regs.a1 <= otm_pkg::RST_CONTROL;
            s_ff.regs.b <= otm_pkg::RST_CONTROL;
            s_ff.regs.c <= otm_pkg::RST_CONTROL;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign prdata_o = s_ff.prdata;
    assign pready_o = s_ff.pready;
    assign pslverr_o = s_ff.pslverr;

    // Mode field decode takes place inside each channel
    for (genvar g = 0; g < otm_pkg::NUM_CHAN; g++) begin : g_chan
        otm_channel u_chan (
            .mclk_i(mclk_i),
            .rst_i(rst_i),
            .mode_i(chan_mode[g]), // RULE_01
            .tick_i(chan_tick[g]),
            .start_i(chan_start[g]),
            .stop_i(chan_stop[g]),
            .reload_i(reload_i[g]),
            .preset_i(preset_i[g]),
            .out_o(chan_out_o[g]),
            .underflow_o(chan_underflow_o[g]),
            .running_o(chan_running_o[g])
        );
    end

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o ##1 !pready_o || (psel_i && !penable_i))
        else $error("pready did not follow setup");
    a_unmapped_error: assert property (psel_i && !penable_i && !(hit_a0 || hit_a1 || hit_b || hit_c)
        |=> pslverr_o && prdata_o == 32'h00000000)
        else $error("unmapped access not refused");
    a_reserved_zero: assert property ((s_ff.regs.a0 & ~otm_pkg::MASK_GROUP_A_CONTROL_0) == 16'h0000
        && (s_ff.regs.a1 & ~otm_pkg::MASK_GROUP_A_CONTROL_1) == 16'h0000
        && (s_ff.regs.b & ~otm_pkg::MASK_GROUP_B_CONTROL) == 16'h0000
        && (s_ff.regs.c & ~otm_pkg::MASK_GROUP_C_CONTROL) == 16'h0000) // RULE_19
        else $error("unassigned control bit is set");
    a_write_readback: assert property (access_wr && hit_a0
        |=> s_ff.regs.a0 == ($past(pwdata_i[15:0]) & otm_pkg::MASK_GROUP_A_CONTROL_0)) // RULE_02
        else $error("group A register 0 write did not land");
    a_unmapped_write: assert property (psel_i && penable_i && pwrite_i && pslverr_o |=> s_ff.regs == $past(s_ff.regs))
        else $error("unmapped write changed a control register");
    a_group_a_start: assert property (ens_a == 3'h4 && event_bus_i[0] && !s_ff.src_prev[0] && !chan_running_o[0]
        && !chan_stop[0] |=> chan_running_o[0]) // RULE_03
        else $error("event bus 0 did not start channel 0");
    a_chain_start: assert property (s_ff.regs.b[otm_pkg::POS_CHAN7_CHAIN_SELECT] && chan_out_o[6]
        && !s_ff.src_prev[3] && !chan_running_o[7] && !chan_stop[7] |=> chan_running_o[7]) // RULE_06
        else $error("channel 6 output did not start channel 7");
    a_group_c_bus3: assert property (cks_c == 2'h3 |-> chan_tick[8] == clk_bus_i[3]) // RULE_20
        else $error("group C code 11 did not count on clock bus 3");
    a_pin_filter: assert property (s_ff.trig[0] != $past(s_ff.trig[0]) |-> $past(s_ff.sync2[0] == s_ff.sync3[0]))
        else $error("pin level changed before stages agreed");
    c_chain_used: cover property (s_ff.regs.b[otm_pkg::POS_CHAN7_CHAIN_SELECT] && chan_start[7] && chan_out_o[6]);
    c_unmapped: cover property (pslverr_o && pready_o);
    c_group_c_bus3: cover property (cks_c == 2'h3 && chan_underflow_o[8]);
endmodule
`default_nettype wire

// ### otm_tick_src.sv
// Count clock bus source model: bus k ticks once every k+1 cycles
`default_nettype none
module otm_tick_src (
    // Clock and reset
    input wire logic mclk_i,
    input wire logic rst_i,
    // Count clock buses
    output logic [3:0] clk_bus_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] div_ff [4];
    always_ff @(posedge mclk_i) begin
        for (int k = 0; k < 4; k++) begin
            if (rst_i || div_ff[k] == 2'(k)) begin
                div_ff[k] <= 2'h0;
            end else begin
                div_ff[k] <= div_ff[k] + 2'h1;
            end
        end
    end
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            clk_bus_o[k] = (div_ff[k] == 2'h0);
        end
    end
endmodule
`default_nettype wire

// ### tb.sv
// Self-checking bench of the output timer mode control block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h00000000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [10:0] chan_en = 11'h000;
    logic [15:0] rl = 16'h0001;
    logic [15:0] pre = 16'h0005;
    logic [3:0] clk_bus;
    logic [3:0] ev_bus = 4'h0;
    logic [2:0] pin = 3'h0;
    logic [10:0] ch_out;
    logic [10:0] ch_uf;
    logic [10:0] ch_run;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0;
    logic [15:0] exp_reg [4] = '{default: 16'h0000};
    // Assigned bits of each register, as laid out for the four registers
    logic [15:0] wmask [4] = '{16'hCEFF, 16'hF000, 16'hCECE, 16'hC8FC};
    logic [31:0] addr [4] = '{otm_pkg::ADDR_GROUP_A_CONTROL_0, otm_pkg::ADDR_GROUP_A_CONTROL_1,
        otm_pkg::ADDR_GROUP_B_CONTROL, otm_pkg::ADDR_GROUP_C_CONTROL};

    otm_control dut (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .chan_enable_i(chan_en), .reload_i({11{rl}}), .preset_i({11{pre}}), .clk_bus_i(clk_bus),
        .event_bus_i(ev_bus), .ext_trigger_a_i(pin[0]), .ext_trigger_b_i(pin[1]), .ext_trigger_c_i(pin[2]),
        .chan_out_o(ch_out), .chan_underflow_o(ch_uf), .chan_running_o(ch_run));
    otm_tick_src src (.mclk_i(mclk_i), .rst_i(rst_i), .clk_bus_o(clk_bus));

    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) cyc <= cyc + 1;

    task automatic test_done;
        if (mismatches == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] want);
        comparisons++;
        if (got !== want) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
        end
    endtask
    // Halfword data only, one aligned word per register
    task automatic apb(input logic wr, input logic [31:0] a, input logic [15:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge mclk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {16'h0000, d};
        @(posedge mclk_i);
        penable <= 1'b1;
        do begin
            @(posedge mclk_i);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) check(32'h0, 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rreg(input int i);
        logic [31:0] rd;
        logic err;
        apb(1'b0, addr[i], 16'h0000, rd, err);
        check(rd, {16'h0000, exp_reg[i]});
    endtask
    task automatic wreg(input int i, input logic [15:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, addr[i], d, rd, err);
        exp_reg[i] = d & wmask[i];
        check({31'h0, err}, 32'h0);
    endtask
    task automatic wait_uf(input int ch, output int t);
        int k;
        k = 0;
        do begin
            @(posedge mclk_i);
            k++;
        end while (ch_uf[ch] !== 1'b1 && k < 1000);
        if (ch_uf[ch] !== 1'b1) check(32'h0, 32'h1);
        t = cyc;
    endtask

    initial begin
        int n;
        int t1;
        int t2;
        int ri;
        int ch;
        int bus;
        int tf [2];
        logic [31:0] rd;
        logic err;
        n = $urandom(28798);
        repeat (4) @(posedge mclk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 4; i++) rreg(i);
        for (int i = 0; i < 4; i++) begin
            wreg(i, 16'hFFFF);
            rreg(i);
            wreg(i, 16'($urandom));
            rreg(i);
            wreg(i, 16'h0000);
        end
        apb(1'b1, addr[0] + 32'h4, 16'hFFFF, rd, err);
        check({31'h0, err}, 32'h1);
        apb(1'b0, addr[0] + 32'h4, 16'h0000, rd, err);
        check(rd, 32'h0);
        rreg(0);
        for (int k = 0; k < 5; k++) begin
            rl <= 16'($urandom_range(4, 1));
            ri = (k < 4) ? 0 : 3;
            ch = (k < 4) ? 0 : 8;
            bus = (k < 4) ? k : 3;
            wreg(ri, {2'(bus), 14'h0080});
            chan_en[ch] <= 1'b1;
            wait_uf(ch, t1);
            wait_uf(ch, t2);
            check(t2 - t1, (rl + 1) * (bus + 1));
            chan_en[ch] <= 1'b0;
            repeat (2) @(posedge mclk_i);
            wreg(ri, 16'h0000);
        end
        pre <= 16'($urandom_range(9, 5));
        for (int m = 0; m < 2; m++) begin
            wreg(0, 16'(m));
            chan_en[3] <= 1'b1;
            t1 = cyc;
            n = 0;
            repeat (60) begin
                @(posedge mclk_i);
                if (ch_uf[3] === 1'b1 && n == 0) tf[m] = cyc - t1;
                if (ch_uf[3] === 1'b1) n++;
            end
            check(n, m + 1);
            check({30'h0, ch_out[3], ch_run[3]}, 32'h0);
            chan_en[3] <= 1'b0;
            repeat (2) @(posedge mclk_i);
        end
        check(tf[1] - tf[0], int'(pre) - int'(rl));
        rl <= 16'h0014;
        for (int c = 0; c < 9; c++) begin
            if (c < 8) begin
                wreg(0, 16'(c << 9));
            end else begin
                wreg(2, 16'h0E00);
                wreg(3, 16'h0800);
            end
            if (c < 4) pin <= 3'h7;
            else ev_bus[(c < 8) ? c % 4 : 3] <= 1'b1;
            n = 0;
            do begin
                @(posedge mclk_i);
                n++;
            end while (ch_run !== ((c > 3 && c < 8) ? 11'h03F : 11'h7FF) && n < 10);
            check(ch_run, (c > 3 && c < 8) ? 32'h03F : 32'h7FF);
            pin <= 3'h0;
            ev_bus <= 4'h0;
            repeat (40) @(posedge mclk_i);
        end
        wreg(3, 16'h0000);
        for (int cb = 0; cb < 2; cb++) begin
            wreg(2, 16'(cb * 2));
            chan_en[6] <= 1'b1;
            repeat (6) @(posedge mclk_i);
            check({31'h0, ch_run[7]}, 32'(cb));
            repeat (40) @(posedge mclk_i);
            chan_en[6] <= 1'b0;
        end
        test_done();
    end

    initial begin
        #300000;
        mismatches++;
        test_done();
    end
endmodule
`default_nettype wire
